/* File: pio_bitop.sv */
// Single-bit merge used by the bit manipulation command.
`timescale 1ns/1ps
module pio_bitop (
    input wire logic [7:0] old_i, // Whole byte as read back.
    input wire logic [2:0] idx_i, // Bit to change.
    input wire logic val_i, // New value of that bit.
    output logic [7:0] new_o // Byte to write back.
);
    logic [7:0] mask;

    always_comb begin
        mask = 8'h01 << idx_i;
        new_o = (old_i & ~mask) | (val_i ? mask : 8'h00);
    end
endmodule // pio_bitop

/* File: pio_board.sv */
// Board model: drives the port 1 to 3 pins that the block leaves undriven.
`timescale 1ns/1ps
module pio_board (
    input wire logic [7:0] p1_o, // Port 1 levels.
    input wire logic [7:0] p1_oe_o, // Port 1 enables.
    input wire logic [7:0] p3_o, // Port 3 levels.
    input wire logic [7:0] p3_oe_o, // Port 3 enables.
    input wire logic [7:0] e1_i, // Board levels, port 1.
    input wire logic [7:0] e2_i, // Board levels, port 2.
    input wire logic [7:0] e3_i, // Board levels, port 3.
    output logic [7:0] p1_i, // Resolved port 1 pins.
    output logic [7:0] p2_i, // Resolved port 2 pins.
    output logic [7:0] p3_i // Resolved port 3 pins.
);
    // The board drives every pin the block releases, so pull-ups never win.
    assign p1_i = (p1_o & p1_oe_o) | (e1_i & ~p1_oe_o);
    assign p2_i = e2_i;
    assign p3_i = (p3_o & p3_oe_o) | (e3_i & ~p3_oe_o);
endmodule // pio_board

/* File: pio_defines.svh */
// Register offsets, field positions and reset values of the port block.
`ifndef PIO_DEFINES_SVH
`define PIO_DEFINES_SVH

// ============================================================
// Register byte offsets
`define PIO_OFS_P0_DATA 8'h00
`define PIO_OFS_P0_DIR 8'h04
`define PIO_OFS_RT_CTL 8'h08
`define PIO_OFS_P1_DATA 8'h0C
`define PIO_OFS_P1_DIR 8'h10
`define PIO_OFS_P2_DATA 8'h14
`define PIO_OFS_P3_DATA 8'h18
`define PIO_OFS_P3_DIR 8'h1C
`define PIO_OFS_P3_FSEL 8'h20
`define PIO_OFS_PULLUP 8'h24
`define PIO_OFS_BITOP 8'h28
`define PIO_OFS_STATUS 8'h2C

// ============================================================
// Field positions
`define PIO_RT_LO_BIT 3
`define PIO_RT_HI_BIT 7
`define PIO_PU_P1_BIT 1
`define PIO_PU_P2_BIT 2
`define PIO_PU_P3_BIT 3
`define PIO_BITOP_IDX_LSB 0
`define PIO_BITOP_TGT_LSB 3
`define PIO_BITOP_VAL_BIT 6
`define PIO_P3_CLR_BIT 4
`define PIO_P3_SI_BIT 5
`define PIO_P3_SO_BIT 6
`define PIO_P3_SCK_BIT 7

// ============================================================
// Values
`define PIO_P0_DRIVE 8'h00
`define PIO_RST_LATCH 8'h00
`define PIO_RST_DIR 8'hFF
`define PIO_RST_FSEL 8'h00
`define PIO_RST_RT_CTL 8'h00
`define PIO_RST_PULLUP 8'h00
`define PIO_P3_INONLY 8'h30
`define PIO_P2_PU_MASK 8'hFC

`endif

/* File: pio_pkg.sv */
// Types shared by the port block modules.
package pio_pkg;

    // Targets of the single-bit manipulation command.
    typedef enum logic [2:0] {
        PIO_TGT_P0_LAT = 3'b000,
        PIO_TGT_RT_CTL = 3'b001,
        PIO_TGT_P1_LAT = 3'b010,
        PIO_TGT_P3_LAT = 3'b011,
        PIO_TGT_P0_DIR = 3'b100,
        PIO_TGT_P1_DIR = 3'b101,
        PIO_TGT_P3_DIR = 3'b110,
        PIO_TGT_PULLUP = 3'b111
    } pio_tgt_e;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic [7:0] p0_lat;
        logic [7:0] p0_dir;
        logic [7:0] rt_ctl;
        logic [7:0] p1_lat;
        logic [7:0] p1_dir;
        logic [7:0] p3_lat;
        logic [7:0] p3_dir;
        logic [7:0] p3_fsel;
        logic [7:0] pu;
        logic refused;
        logic [7:0] p0_oe;
        logic [7:0] p1_oe;
        logic [7:0] p1_pu;
        logic [7:0] p2_pu;
        logic [7:0] p3_o;
        logic [7:0] p3_oe;
        logic [7:0] p3_pu;
        logic [7:0] p2_alt;
        logic t0clr;
        logic si;
        logic sckin;
    } pio_state_s;

endpackage

/* File: pio_ports.sv */
// Ports 0 to 3 with direction (ports 0, 1, 3), function select (port 3) and pull-up control (ports 1 to 3).
`timescale 1ns/1ps
`include "pio_defines.svh"
module pio_ports
    import pio_pkg::*;
(
    input wire logic clk_i, // System clock, 10 MHz.
    input wire logic rst_i, // Synchronous reset, active high.
    input wire logic wb_cyc_i, // Wishbone cycle.
    input wire logic wb_stb_i, // Wishbone strobe.
    input wire logic wb_we_i, // Wishbone write enable.
    input wire logic [7:0] wb_adr_i, // Wishbone byte address.
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
    input wire logic [31:0] wb_dat_i, // Wishbone write data.
    output logic [31:0] wb_dat_o, // Wishbone read data.
    output logic wb_ack_o, // Wishbone acknowledge.
    output logic [7:0] p0_o, // Port 0 pin output levels.
    output logic [7:0] p0_oe_o, // Port 0 output enables.
    input wire logic [7:0] p1_i, // Port 1 pin levels.
    output logic [7:0] p1_o, // Port 1 pin output levels.
    output logic [7:0] p1_oe_o, // Port 1 output enables.
    output logic [7:0] p1_pu_o, // Port 1 pull-up enables.
    input wire logic [7:0] p2_i, // Port 2 pin levels.
    output logic [7:0] p2_pu_o, // Port 2 pull-up enables.
    input wire logic [7:0] p3_i, // Port 3 pin levels.
    output logic [7:0] p3_o, // Port 3 pin output levels.
    output logic [7:0] p3_oe_o, // Port 3 output enables.
    output logic [7:0] p3_pu_o, // Port 3 pull-up enables.
    output logic nmi_o, // Nonmaskable interrupt input level.
    output logic ext_irq0_o, // External interrupt 0 level.
    output logic ext_irq1_o, // External interrupt 1 level.
    output logic ext_irq2_o, // External interrupt 2 level.
    output logic capture_trig_a_o, // Capture trigger a level.
    output logic capture_trig_b_o, // Capture trigger b level.
    output logic capture_trig_c_o, // Capture trigger c level.
    output logic counter_clear_in_o, // Counter capture clear level.
    input wire logic timer0_out0_i, // Timer 0 output 0.
    input wire logic timer0_out1_i, // Timer 0 output 1.
    input wire logic timer0_out2_i, // Timer 0 output 2.
    input wire logic timer1_out1_i, // Timer 1 output 1.
    output logic timer0_clear_in_o, // Timer 0 clear input level.
    output logic sio_si_o, // Serial data input level.
    input wire logic sio_so_i, // Serial data output value.
    input wire logic sio_so_oe_i, // Serial data output enable.
    input wire logic sio_sck_i, // Serial clock output value.
    input wire logic sio_sck_oe_i, // Serial clock output enable.
    output logic sio_sck_in_o // Serial clock input level.
);

    // ============================================================
    // Pin synchronisers
    logic [23:0] pins_sync;
    logic [7:0] p1_pin;
    logic [7:0] p2_pin;
    logic [7:0] p3_pin;

    pio_sync #(
        .WIDTH(24)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({p3_i, p2_i, p1_i}),
        .q_o(pins_sync)
    );

    assign p1_pin = pins_sync[7:0];
    assign p2_pin = pins_sync[15:8];
    assign p3_pin = pins_sync[23:16];

    // ============================================================
    // State
    pio_state_s s_r;
    pio_state_s s_nxt;

    logic req;
    logic wr;
    logic [7:0] wbyte;
    logic [7:0] p1_read;
    logic [7:0] p3_in_mode;
    logic [7:0] p3_read;
    logic [7:0] bit_old;
    logic [7:0] bit_new;
    logic [2:0] bit_idx;
    logic bit_val;
    pio_tgt_e bit_tgt;
    logic rt_force;

    assign req = wb_cyc_i & wb_stb_i & ~s_r.ack;
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign wbyte = wb_dat_i[7:0];
    assign bit_idx = wb_dat_i[`PIO_BITOP_IDX_LSB +: 3];
    assign bit_val = wb_dat_i[`PIO_BITOP_VAL_BIT];
    assign bit_tgt = pio_tgt_e'(wb_dat_i[`PIO_BITOP_TGT_LSB +: 3]);

    // ============================================================
    // Read-back views of the ports
    // one is input
    // Input pins read the pin, output pins read their latch.
    assign p1_read = (p1_pin & s_r.p1_dir) | (s_r.p1_lat & ~s_r.p1_dir);

    // port-mode inputs only
    // Pins 4 and 5 count as inputs while in port mode, whatever their
    // direction bits say; in control mode the direction bit decides.
    assign p3_in_mode = s_r.p3_dir | (`PIO_P3_INONLY & ~s_r.p3_fsel);
    assign p3_read = (p3_pin & (p3_in_mode | s_r.p3_fsel))
        | (s_r.p3_lat & ~(p3_in_mode | s_r.p3_fsel));

    // byte read-back
    // The whole byte is read and written back, so latches of input
    // pins take up whatever level their pins show at that moment.
    always_comb begin
        unique case (bit_tgt)
            PIO_TGT_P0_LAT: bit_old = s_r.p0_lat;
            PIO_TGT_RT_CTL: bit_old = s_r.rt_ctl;
            PIO_TGT_P1_LAT: bit_old = p1_read;
            PIO_TGT_P3_LAT: bit_old = p3_read;
            PIO_TGT_PULLUP: bit_old = s_r.pu;
            PIO_TGT_P0_DIR,
            PIO_TGT_P1_DIR,
            PIO_TGT_P3_DIR: bit_old = 8'h00;
        endcase
    end

    pio_bitop u_bitop (
        .old_i(bit_old),
        .idx_i(bit_idx),
        .val_i(bit_val),
        .new_o(bit_new)
    );

    assign rt_force = s_r.rt_ctl[`PIO_RT_LO_BIT] & s_r.rt_ctl[`PIO_RT_HI_BIT];

    // ============================================================
    // Next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.ack = req;
        s_nxt.dat = 32'h0000_0000;

        // Register writes take effect at the edge that raises ack.
        if (wr) begin
            unique case (wb_adr_i)
                `PIO_OFS_P0_DATA: s_nxt.p0_lat = wbyte;
                `PIO_OFS_P0_DIR: s_nxt.p0_dir = wbyte;
                `PIO_OFS_RT_CTL: s_nxt.rt_ctl = wbyte;
                `PIO_OFS_P1_DATA: s_nxt.p1_lat = wbyte;
                `PIO_OFS_P1_DIR: s_nxt.p1_dir = wbyte;
                `PIO_OFS_P3_DATA: s_nxt.p3_lat = wbyte;
                `PIO_OFS_P3_DIR: s_nxt.p3_dir = wbyte;
                `PIO_OFS_P3_FSEL: s_nxt.p3_fsel = wbyte;
                `PIO_OFS_PULLUP: s_nxt.pu = wbyte;
                `PIO_OFS_BITOP: begin
                    unique case (bit_tgt)
                        PIO_TGT_RT_CTL: s_nxt.rt_ctl = bit_new;
                        PIO_TGT_P0_LAT: s_nxt.p0_lat = bit_new;
                        PIO_TGT_P1_LAT: s_nxt.p1_lat = bit_new;
                        PIO_TGT_P3_LAT: s_nxt.p3_lat = bit_new;
                        PIO_TGT_PULLUP: s_nxt.pu = bit_new;
                        // no bit operation
                        // Direction registers refuse bit operations; the
                        // attempt is only recorded in the status flag.
                        PIO_TGT_P0_DIR,
                        PIO_TGT_P1_DIR,
                        PIO_TGT_P3_DIR: s_nxt.refused = 1'b1;
                    endcase
                end
                `PIO_OFS_STATUS: begin
                    // Write one clears the flag; a new refusal in the
                    // same cycle cannot arrive, as both share the bus.
                    if (wbyte[0]) begin
                        s_nxt.refused = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Reads; unmapped addresses read zero and are still acked.
        if (req & ~wb_we_i) begin
            unique case (wb_adr_i)
                `PIO_OFS_P0_DATA: s_nxt.dat[7:0] = s_r.p0_lat;
                `PIO_OFS_P0_DIR: s_nxt.dat[7:0] = s_r.p0_dir;
                `PIO_OFS_RT_CTL: s_nxt.dat[7:0] = s_r.rt_ctl;
                `PIO_OFS_P1_DATA: s_nxt.dat[7:0] = p1_read;
                `PIO_OFS_P1_DIR: s_nxt.dat[7:0] = s_r.p1_dir;
                `PIO_OFS_P2_DATA: s_nxt.dat[7:0] = p2_pin;
                `PIO_OFS_P3_DATA: s_nxt.dat[7:0] = p3_read;
                `PIO_OFS_P3_DIR: s_nxt.dat[7:0] = s_r.p3_dir;
                `PIO_OFS_P3_FSEL: s_nxt.dat[7:0] = s_r.p3_fsel;
                `PIO_OFS_PULLUP: s_nxt.dat[7:0] = s_r.pu;
                `PIO_OFS_STATUS: s_nxt.dat[0] = s_r.refused;
                default: s_nxt.dat = 32'h0000_0000;
            endcase
        end

        // ========================================================
        // Port 0 buffer control
        // float when off
        // no pull-ups
        // Port 0 has no pull-up output, and no pull-up bit is read here.
        if (rt_force || s_r.p0_dir == `PIO_P0_DRIVE) begin
            s_nxt.p0_oe = 8'hFF;
        end else begin
            s_nxt.p0_oe = 8'h00;
        end

        // ========================================================
        // Port 1
        // zero drives
        s_nxt.p1_oe = ~s_r.p1_dir;
        s_nxt.p1_pu = s_r.pu[`PIO_PU_P1_BIT] ? s_r.p1_dir : 8'h00;

        // ========================================================
        // Port 2
        // grouped pull-up
        s_nxt.p2_pu = s_r.pu[`PIO_PU_P2_BIT] ? `PIO_P2_PU_MASK : 8'h00;
        s_nxt.p2_alt = p2_pin;

        // ========================================================
        // Port 3
        // per-bit direction
        s_nxt.p3_o = s_r.p3_lat;
        s_nxt.p3_oe = ~p3_in_mode;
        // control use
        // Timer outputs take pins 0 to 3 over completely; the serial
        // unit decides itself when its data and clock pins drive.
        if (s_r.p3_fsel[0]) begin
            s_nxt.p3_o[0] = timer0_out0_i;
            s_nxt.p3_oe[0] = 1'b1;
        end
        if (s_r.p3_fsel[1]) begin
            s_nxt.p3_o[1] = timer0_out1_i;
            s_nxt.p3_oe[1] = 1'b1;
        end
        if (s_r.p3_fsel[2]) begin
            s_nxt.p3_o[2] = timer0_out2_i;
            s_nxt.p3_oe[2] = 1'b1;
        end
        if (s_r.p3_fsel[3]) begin
            s_nxt.p3_o[3] = timer1_out1_i;
            s_nxt.p3_oe[3] = 1'b1;
        end
        if (s_r.p3_fsel[`PIO_P3_CLR_BIT]) begin
            s_nxt.p3_oe[`PIO_P3_CLR_BIT] = 1'b0;
        end
        if (s_r.p3_fsel[`PIO_P3_SI_BIT]) begin
            s_nxt.p3_oe[`PIO_P3_SI_BIT] = 1'b0;
        end
        if (s_r.p3_fsel[`PIO_P3_SO_BIT]) begin
            s_nxt.p3_o[`PIO_P3_SO_BIT] = sio_so_i;
            s_nxt.p3_oe[`PIO_P3_SO_BIT] = sio_so_oe_i;
        end
        if (s_r.p3_fsel[`PIO_P3_SCK_BIT]) begin
            s_nxt.p3_o[`PIO_P3_SCK_BIT] = sio_sck_i;
            s_nxt.p3_oe[`PIO_P3_SCK_BIT] = sio_sck_oe_i;
        end
        // bits 4, 5 included
        // Control-mode pins are pulled up whenever their direction bit
        // says input, so software must clear it to avoid the load.
        s_nxt.p3_pu = s_r.pu[`PIO_PU_P3_BIT] ? p3_in_mode : 8'h00;
        // Control inputs see their pins only while selected, so an
        // idle unit does not pick up port traffic.
        s_nxt.t0clr = s_r.p3_fsel[`PIO_P3_CLR_BIT]
            & p3_pin[`PIO_P3_CLR_BIT];
        s_nxt.si = s_r.p3_fsel[`PIO_P3_SI_BIT] & p3_pin[`PIO_P3_SI_BIT];
        s_nxt.sckin = s_r.p3_fsel[`PIO_P3_SCK_BIT]
            & p3_pin[`PIO_P3_SCK_BIT];
    end

    // ============================================================
    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
            s_r.p0_lat <= `PIO_RST_LATCH;
            s_r.p0_dir <= `PIO_RST_DIR;
            s_r.rt_ctl <= `PIO_RST_RT_CTL;
            s_r.p1_lat <= `PIO_RST_LATCH;
            s_r.p1_dir <= `PIO_RST_DIR;
            s_r.p3_lat <= `PIO_RST_LATCH;
            s_r.p3_dir <= `PIO_RST_DIR;
            s_r.p3_fsel <= `PIO_RST_FSEL;
            s_r.pu <= `PIO_RST_PULLUP;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ============================================================
    // Outputs, all straight from the state register
    assign wb_dat_o = s_r.dat;
    assign wb_ack_o = s_r.ack;
    assign p0_o = s_r.p0_lat;
    assign p0_oe_o = s_r.p0_oe;
    assign p1_o = s_r.p1_lat;
    assign p1_oe_o = s_r.p1_oe;
    assign p1_pu_o = s_r.p1_pu;
    assign p2_pu_o = s_r.p2_pu;
    assign p3_o = s_r.p3_o;
    assign p3_oe_o = s_r.p3_oe;
    assign p3_pu_o = s_r.p3_pu;
    assign nmi_o = s_r.p2_alt[0];
    assign ext_irq0_o = s_r.p2_alt[1];
    assign ext_irq1_o = s_r.p2_alt[2];
    assign ext_irq2_o = s_r.p2_alt[3];
    assign capture_trig_a_o = s_r.p2_alt[4];
    assign capture_trig_b_o = s_r.p2_alt[5];
    assign capture_trig_c_o = s_r.p2_alt[6];
    assign counter_clear_in_o = s_r.p2_alt[7];
    assign timer0_clear_in_o = s_r.t0clr;
    assign sio_si_o = s_r.si;
    assign sio_sck_in_o = s_r.sckin;

endmodule // pio_ports

/* File: pio_ports_sva.sv */
// Checker of bus timing and pin control outputs of the port block.
`timescale 1ns/1ps
module pio_ports_chk (
    input wire logic clk_i, // Clock.
    input wire logic rst_i, // Reset.
    input wire logic wb_cyc_i, // Cycle.
    input wire logic wb_stb_i, // Strobe.
    input wire logic wb_we_i, // Write.
    input wire logic [7:0] wb_adr_i, // Address.
    input wire logic [3:0] wb_sel_i, // Selects.
    input wire logic [31:0] wb_dat_i, // Write data.
    input wire logic wb_ack_o, // Acknowledge.
    input wire logic [7:0] p0_oe_o, // Port 0 enables.
    input wire logic [7:0] p1_oe_o, // Port 1 enables.
    input wire logic [7:0] p1_pu_o, // Port 1 pull-ups.
    input wire logic [7:0] p2_i, // Port 2 pins.
    input wire logic [7:0] p2_pu_o, // Port 2 pull-ups.
    input wire logic [7:0] p3_oe_o, // Port 3 enables.
    input wire logic [7:0] p3_pu_o, // Port 3 pull-ups.
    input wire logic nmi_o, // Port 2 bit 0 level.
    input wire logic counter_clear_in_o, // Port 2 bit 7 level.
    input wire logic timer0_clear_in_o // Port 3 bit 4 level.
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ============================================================
    // Helpers
    // Counts edges since reset so the pin pipeline holds no stale data.
    logic [1:0] up_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) up_r <= 2'h0;
        else if (up_r != 2'h3) up_r <= up_r + 2'h1;
    end
    sequence wr_take(logic [7:0] a);
        wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] &&
            wb_adr_i == a;
    endsequence
    sequence ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    // ============================================================
    // Assertions
    ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> ack_once) else $error("ack is not a single pulse");
    p0_group_a: assert property (p0_oe_o == 8'h00 || p0_oe_o == 8'hFF)
        else $error("port 0 enables split");
    rt_force_a: assert property (wr_take(8'h08) ##0 wb_dat_i[3] &&
        wb_dat_i[7] |=> ##1 p0_oe_o == 8'hFF)
        else $error("port 0 buffers not forced on");
    p1_dir_a: assert property (wr_take(8'h10)
        |=> ##1 p1_oe_o == ~$past(wb_dat_i[7:0], 2))
        else $error("port 1 enables differ from direction");
    p1_pu_in_a: assert property ((p1_pu_o & p1_oe_o) == 8'h00)
        else $error("pull-up on driven port 1 pin");
    p2_pu_grp_a: assert property (p2_pu_o == 8'h00 || p2_pu_o == 8'hFC)
        else $error("port 2 pull-ups not grouped");
    p3_in_only_a: assert property (p3_oe_o[5:4] == 2'b00)
        else $error("port 3 bit 4 or 5 driven");
    p3_pu_off_a: assert property (wr_take(8'h24) ##0 !wb_dat_i[3]
        |=> ##1 p3_pu_o == 8'h00) else $error("port 3 pull-up stays on");
    alt_follow_a: assert property (up_r == 2'h3 |->
        {counter_clear_in_o, nmi_o} == {$past(p2_i[7], 3), $past(p2_i[0], 3)})
        else $error("port 2 alternate inputs lag wrongly");
    clr_gate_a: assert property (wr_take(8'h20) ##0 !wb_dat_i[4]
        |=> ##1 !timer0_clear_in_o) else $error("clear input not gated");
endmodule // pio_ports_chk

/* File: pio_sync.sv */
// Two-flop synchroniser for a bus of pin inputs.
`timescale 1ns/1ps
module pio_sync #(
    parameter int WIDTH = 24
) (
    input wire logic clk_i, // System clock.
    input wire logic rst_i, // Synchronous reset, active high.
    input wire logic [WIDTH-1:0] d_i, // Asynchronous pin levels.
    output logic [WIDTH-1:0] q_o // Synchronised levels.
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] q_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= d_i;
            q_r <= meta_r;
        end
    end

    assign q_o = q_r;
endmodule // pio_sync

/* File: tb_pio_ports.sv */
// Self-checking bench of the port block.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    err_total++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_pio_ports;
    import pio_pkg::*;
    logic clk_i, rst_i, cyc, stb, we;
    logic [7:0] adr, e1, e2, e3, ctl, d;
    logic [31:0] wdat, wb_dat_o;
    logic wb_ack_o, nmi_o, ccl_o, t0c_o;
    logic ei0, ei1, ei2, cta, ctb, ctc, si_o, sck_o;
    logic [3:0] sel;
    logic [7:0] exp_rd;
    logic [7:0] p0_o, p0_oe, p1_o, p1_oe, p1_pu, p2_pu, p3_o, p3_oe, p3_pu;
    logic [7:0] p1_i, p2_i, p3_i;
    logic [7:0] exp_q[$];
    int err_total, checks_done;
    pio_ports u_pio_ports (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o, .wb_ack_o, .p0_o, .p0_oe_o(p0_oe), .p1_i, .p1_o,
        .p1_oe_o(p1_oe), .p1_pu_o(p1_pu), .p2_i, .p2_pu_o(p2_pu), .p3_i,
        .p3_o, .p3_oe_o(p3_oe), .p3_pu_o(p3_pu), .nmi_o, .ext_irq0_o(ei0),
        .ext_irq1_o(ei1), .ext_irq2_o(ei2), .capture_trig_a_o(cta),
        .capture_trig_b_o(ctb), .capture_trig_c_o(ctc),
        .counter_clear_in_o(ccl_o),
        .timer0_out0_i(ctl[0]), .timer0_out1_i(ctl[1]),
        .timer0_out2_i(ctl[2]), .timer1_out1_i(ctl[3]),
        .timer0_clear_in_o(t0c_o), .sio_si_o(si_o), .sio_so_i(ctl[4]),
        .sio_so_oe_i(ctl[6]), .sio_sck_i(ctl[5]), .sio_sck_oe_i(ctl[7]),
        .sio_sck_in_o(sck_o));
    pio_board u_pio_board (.p1_o, .p1_oe_o(p1_oe), .p3_o, .p3_oe_o(p3_oe),
        .e1_i(e1), .e2_i(e2), .e3_i(e3), .p1_i, .p2_i, .p3_i);
    always #50 clk_i = ~clk_i;
    // ============================================================
    // Tasks
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Classic cycle; read expectations go to the queue before the request.
    task automatic wb(input logic w, input logic [7:0] a,
            input logic [7:0] v, input logic [7:0] x = 8'h00,
            input logic [3:0] s = 4'h1);
        int n;
        if (!w) exp_q.push_back(x);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= {24'h0, v};
        n = 0;
        do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 50);
        if (wb_ack_o !== 1'b1) begin
            err_total++;
            $display("[ERR] bus ack exp 1 got %b", wb_ack_o);
            stop_test();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    // Reading at the edge sees what the previous edge settled.
    task automatic settle(int n = 1);
        repeat (n) @(posedge clk_i);
    endtask
    // ============================================================
    // Read data monitor
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && we === 1'b0) begin
            if (exp_q.size() == 0) begin
                err_total++;
                $display("[ERR] read data exp none got %h", wb_dat_o);
            end else begin
                exp_rd = exp_q.pop_front();
                `CHK("read data", {24'h0, exp_rd}, wb_dat_o)
            end
        end
    end
    // ============================================================
    // Main sequence
    logic [7:0] ra[8] = '{8'h04, 8'h10, 8'h1C, 8'h20, 8'h24, 8'h08, 8'h00, 8'h30};
    logic [7:0] rv[8] = '{8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    initial begin
        clk_i = 0; rst_i = 1; cyc = 0; stb = 0; we = 0; adr = 0; wdat = 0;
        e1 = 0; e2 = 0; e3 = 0; ctl = 0; d = 0; sel = 4'h0;
        void'($urandom(23));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (ra[i]) wb(0, ra[i], 8'h00, rv[i]);
        $display("T1 reset values done");
        d = 8'($urandom);
        wb(1, 8'h00, d); wb(1, 8'h04, 8'h00); settle();
        `CHK("p0 oe", 8'hFF, p0_oe)
        `CHK("p0 out", d, p0_o)
        // A write without byte lane 0 must leave the latch alone.
        wb(1, 8'h00, ~d, 8'h00, 4'hE); wb(0, 8'h00, 8'h00, d);
        wb(1, 8'h04, 8'h01); settle();
        `CHK("p0 float", 8'h00, p0_oe)
        wb(1, 8'h08, 8'h88); settle();
        `CHK("p0 forced", 8'hFF, p0_oe)
        wb(1, 8'h08, 8'h08); wb(1, 8'h28, 8'h4F);
        wb(0, 8'h08, 8'h00, 8'h88);
        wb(1, 8'h28, 8'h60); wb(0, 8'h2C, 8'h00, 8'h01);
        wb(0, 8'h04, 8'h00, 8'h01); wb(1, 8'h2C, 8'h01);
        $display("T2 port 0 done");
        d = 8'($urandom); e1 <= 8'($urandom);
        wb(1, 8'h0C, 8'h00); wb(1, 8'h10, d); wb(1, 8'h24, 8'h02); settle();
        `CHK("p1 oe", ~d, p1_oe)
        `CHK("p1 pu", d, p1_pu)
        wb(0, 8'h0C, 8'h00, e1 & d);
        wb(1, 8'h28, 8'h50); wb(1, 8'h10, 8'h00); settle();
        `CHK("p1 rmw", (e1 & d) | 8'h01, p1_o)
        `CHK("p1 pu out", 8'h00, p1_pu)
        $display("T3 port 1 done");
        e2 <= 8'($urandom);
        wb(1, 8'h24, 8'h04); settle(4);
        `CHK("p2 pu", 8'hFC, p2_pu)
        `CHK("nmi", e2[0], nmi_o)
        `CHK("clear in", e2[7], ccl_o)
        `CHK("p2 alt", e2, {ccl_o, ctc, ctb, cta, ei2, ei1, ei0, nmi_o})
        wb(0, 8'h14, 8'h00, e2);
        $display("T4 port 2 done");
        // Pin 4 is held high so that gating of the clear input shows.
        d = 8'($urandom); e3 <= 8'($urandom) | 8'h10; ctl <= 8'($urandom);
        wb(1, 8'h1C, d); wb(1, 8'h24, 8'h08); settle();
        `CHK("p3 pu", d | 8'h30, p3_pu)
        `CHK("p3 oe", ~(d | 8'h30), p3_oe)
        wb(1, 8'h20, 8'hFF); settle(4);
        `CHK("p3 ctl pu", d, p3_pu)
        `CHK("p3 ctl oe", {ctl[7:6], 6'h0F}, p3_oe)
        `CHK("p3 timer", ctl[3:0], p3_o[3:0])
        `CHK("t0 clear", e3[4], t0c_o)
        `CHK("si in", e3[5], si_o)
        `CHK("sck in", ctl[7] ? ctl[5] : e3[7], sck_o)
        wb(1, 8'h1C, 8'h00); settle();
        `CHK("p3 pu off", 8'h00, p3_pu)
        wb(1, 8'h20, 8'h00); settle();
        `CHK("t0 gated", 1'b0, t0c_o)
        wb(1, 8'h24, 8'h00);
        $display("T5 port 3 done");
        stop_test();
    end
endmodule // tb_pio_ports
bind pio_ports pio_ports_chk u_pio_ports_chk (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
    .p0_oe_o, .p1_oe_o, .p1_pu_o, .p2_i, .p2_pu_o, .p3_oe_o, .p3_pu_o,
    .nmi_o, .counter_clear_in_o, .timer0_clear_in_o);
